// file: rtl/general_purpose_timer_pair.sv
// Purpose: Two 16-bit timers, joinable as a 32-bit timer or a 1 Hz calendar counter
// Assumes: Avalon-MM slave with one wait state; calendar clock on capture_pin_zero
// Notes:   Capture, edge count and PWM modes are not implemented
//
// The Avalon-MM interface to the registers and the address map were decided locally.

module general_purpose_timer_pair
	import gpt_pkg::*;
#(
	parameter int RTC_DIV = RTC_DIV_DEF
) (
	input  wire logic              core_clk,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	input  wire logic              capture_pin_zero,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	output logic                   irq,
	output logic                   adc_trigger
);
	localparam int DIV_W = $clog2(RTC_DIV + 1);

	bus_state_t        state;
	logic [2:0]        cfg;
	logic [1:0]        mode [2];
	ctl_t              ctl;
	logic [31:0]       imr;
	logic [31:0]       ris;
	logic [15:0]       ilr [2];
	logic [7:0]        pr [2];
	logic [31:0]       match;
	logic [15:0]       cnt [2];
	logic [7:0]        pre [2];
	logic [31:0]       rd_mux;
	logic [31:0]       wm;
	logic [31:0]       joined;
	logic [31:0]       next32;
	logic              acc_wr;
	logic              is_tmr32;
	logic              is_rtc;
	logic              is_split;
	logic              run32;
	logic              to32;
	logic              rtc_entry;
	logic              rtc_run;
	logic              rtc_hit;
	logic              rtc_tick;
	logic              cap_s1;
	logic              cap_s2;
	logic              cap_s3;
	logic [DIV_W-1:0]  div_cnt;
	logic [1:0]        ld16;
	logic [1:0]        run16;
	logic [1:0]        to16;
	logic              to_a;
	logic              to_b;
	logic [1:0]        oneshot_done;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] ctl_word(input ctl_t c);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[CTL_A_EN]    = c.tmr[0].en;
		w[CTL_A_STALL] = c.tmr[0].stall;
		w[CTL_A_OTE]   = c.tmr[0].ote;
		w[CTL_RTC_EN]  = c.rtc_en;
		w[CTL_B_EN]    = c.tmr[1].en;
		w[CTL_B_STALL] = c.tmr[1].stall;
		w[CTL_B_OTE]   = c.tmr[1].ote;
		return w;
	endfunction

	assign is_tmr32 = (cfg == CFG_JOIN_TMR);
	assign is_rtc   = (cfg == CFG_JOIN_RTC);
	assign is_split = (cfg == CFG_SPLIT);
	assign joined   = {cnt[1], cnt[0]};

	// Bus slave: one wait state, access takes effect on the edge with waitrequest low
	assign acc_wr = (state == BUS_ACK) && write;
	assign wm     = merge(rd_mux, writedata, byteenable);

	always_comb begin
		case (address)
			OFF_CFG:   rd_mux = {29'h0, cfg};
			OFF_FIRST_MODE_FIELD:  rd_mux = {30'h0, mode[0]};
			OFF_TBMR:  rd_mux = {30'h0, mode[1]};
			OFF_CTL:   rd_mux = ctl_word(ctl);
			OFF_IMR:   rd_mux = imr;
			OFF_RIS:   rd_mux = ris;
			OFF_MIS:   rd_mux = ris & imr;
			OFF_TAILR: rd_mux = is_split ? {16'h0, ilr[0]} : {ilr[1], ilr[0]};
			OFF_TBILR: rd_mux = {16'h0, ilr[1]};
			OFF_MATCH: rd_mux = match;
			OFF_TAPR:  rd_mux = {24'h0, pr[0]};
			OFF_TBPR:  rd_mux = {24'h0, pr[1]};
			OFF_TAR:   rd_mux = is_split ? {16'h0, cnt[0]} : joined;
			OFF_TBR:   rd_mux = {16'h0, cnt[1]};
			default:   rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state       <= BUS_IDLE;
			waitrequest <= 1'b1;
			readdata    <= 32'h0000_0000;
		end else begin
			case (state)
				BUS_IDLE: begin
					if (read || write) begin
						state       <= BUS_ACK;
						waitrequest <= 1'b0;
						readdata    <= read ? rd_mux : 32'h0000_0000;
					end
				end
				BUS_ACK: begin
					state       <= BUS_IDLE;
					waitrequest <= 1'b1;
				end
				default: begin
					state       <= BUS_IDLE;
					waitrequest <= 1'b1;
				end
			endcase
		end
	end

	// Configuration registers
	assign rtc_entry = acc_wr && (address == OFF_CFG) && (wm[2:0] == CFG_JOIN_RTC) && !is_rtc;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg     <= 3'h0;
			mode[0] <= 2'h0;
			mode[1] <= 2'h0;
			imr     <= 32'h0000_0000;
			match   <= 32'h0000_0000;
			pr[0]   <= PR_RST;
			pr[1]   <= PR_RST;
		end else if (acc_wr) begin
			case (address)
				OFF_CFG:   cfg <= wm[2:0];
				OFF_FIRST_MODE_FIELD:  mode[0] <= wm[1:0];
				OFF_TBMR:  mode[1] <= wm[1:0];
				OFF_IMR:   imr <= wm & IRQ_BITS;
				OFF_MATCH: match <= wm;
				OFF_TAPR:  pr[0] <= wm[7:0];
				OFF_TBPR:  pr[1] <= wm[7:0];
				default: begin
				end
			endcase
		end
	end

	// Interval loads; a joined write lands in both halves
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ilr[0] <= ILR_RST;
			ilr[1] <= ILR_RST;
		end else if (acc_wr && address == OFF_TAILR) begin
			ilr[0] <= wm[15:0];
			if (!is_split) begin
				ilr[1] <= wm[31:16];
			end
		end else if (acc_wr && address == OFF_TBILR) begin
			ilr[1] <= wm[15:0];
		end
	end

	// Control: a software write beats a hardware one-shot clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctl <= '0;
		end else if (acc_wr && address == OFF_CTL) begin
			ctl.tmr[0].en    <= wm[CTL_A_EN];
			ctl.tmr[0].stall <= wm[CTL_A_STALL];
			ctl.tmr[0].ote   <= wm[CTL_A_OTE];
			ctl.rtc_en       <= wm[CTL_RTC_EN];
			ctl.tmr[1].en    <= wm[CTL_B_EN];
			ctl.tmr[1].stall <= wm[CTL_B_STALL];
			ctl.tmr[1].ote   <= wm[CTL_B_OTE];
		end else begin
			if (oneshot_done[0]) begin
				ctl.tmr[0].en <= 1'b0;
			end
			if (oneshot_done[1]) begin
				ctl.tmr[1].en <= 1'b0;
			end
		end
	end

	// Calendar input: pin synchroniser and divide to 1 Hz
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_s1 <= 1'b0;
			cap_s2 <= 1'b0;
			cap_s3 <= 1'b0;
		end else begin
			cap_s1 <= capture_pin_zero;
			cap_s2 <= cap_s1;
			cap_s3 <= cap_s2;
		end
	end

	assign rtc_tick = cap_s2 && !cap_s3 && (div_cnt == DIV_W'(RTC_DIV - 1));

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= '0;
		end else if (!(is_rtc && ctl.tmr[0].en)) begin
			div_cnt <= '0;
		end else if (cap_s2 && !cap_s3) begin
			div_cnt <= rtc_tick ? '0 : div_cnt + 1'b1;
		end
	end

	// Joined counter next value
	assign run32 = is_tmr32 && ctl.tmr[0].en && !ctl.tmr[0].stall &&
		(mode[0] == MODE_ONESHOT || mode[0] == MODE_PERIODIC);
	assign to32  = run32 && (joined == 32'h0000_0000);
	// Calendar ignores freeze bits only while its own enable is set
	assign rtc_run = is_rtc && ctl.tmr[0].en && rtc_tick &&
		(ctl.rtc_en || !(ctl.tmr[0].stall || ctl.tmr[1].stall));
	assign rtc_hit = rtc_run && (joined == match);

	always_comb begin
		next32 = joined;
		if (rtc_entry) begin
			next32 = RTC_PRELOAD;
		end else if (is_tmr32 && acc_wr && address == OFF_TAILR) begin
			next32 = wm;
		end else if (to32) begin
			next32 = {ilr[1], ilr[0]};
		end else if (run32) begin
			next32 = joined - 32'h0000_0001;
		end else if (rtc_hit) begin
			next32 = 32'h0000_0000;
		end else if (rtc_run) begin
			next32 = joined + 32'h0000_0001;
		end
	end

	assign ld16[0] = acc_wr && address == OFF_TAILR;
	assign ld16[1] = acc_wr && address == OFF_TBILR;

	// Per timer counters; joined modes take their half of next32
	for (genvar i = 0; i < 2; i++) begin : g_tmr
		assign run16[i] = is_split && ctl.tmr[i].en && !ctl.tmr[i].stall &&
			(mode[i] == MODE_ONESHOT || mode[i] == MODE_PERIODIC);
		assign to16[i] = run16[i] && cnt[i] == 16'h0000 && pre[i] == 8'h00;

		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				cnt[i] <= CNT_RST;
				pre[i] <= PR_RST;
			end else if (!is_split || rtc_entry) begin
				// Calendar preload must land even when entered from split mode
				cnt[i] <= next32[16*i +: 16];
			end else if (ld16[i]) begin
				cnt[i] <= wm[15:0];
				pre[i] <= pr[i];
			end else if (to16[i]) begin
				cnt[i] <= ilr[i];
				pre[i] <= pr[i];
			end else if (run16[i]) begin
				if (pre[i] == 8'h00) begin
					cnt[i] <= cnt[i] - 16'h0001;
					pre[i] <= pr[i];
				end else begin
					pre[i] <= pre[i] - 8'h01;
				end
			end
		end
	end

	assign to_a = to32 || to16[0];
	assign to_b = to16[1];
	assign oneshot_done[0] = to_a && mode[0] == MODE_ONESHOT;
	assign oneshot_done[1] = to_b && mode[1] == MODE_ONESHOT;

	// Sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ris <= 32'h0000_0000;
		end else begin
			ris <= (ris & ~((acc_wr && address == OFF_ICR) ? wm : 32'h0000_0000))
				| (32'(to_a) << IRQ_A_TO)
				| (32'(rtc_hit) << IRQ_RTC)
				| (32'(to_b) << IRQ_B_TO);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq         <= 1'b0;
			adc_trigger <= 1'b0;
		end else begin
			irq         <= |(ris & imr);
			// Triggers of all blocks are ORed outside, so only one should be enabled
			adc_trigger <= (to_a && ctl.tmr[0].ote) || (to_b && ctl.tmr[1].ote);
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_load_write;
		is_split && acc_wr && address == OFF_TAILR;
	endsequence

	property p_reset_state;
		$rose(rst_n) |-> cnt[0] == CNT_RST && cnt[1] == CNT_RST && ilr[0] == ILR_RST && pre[0] == PR_RST && !ctl.tmr[0].en;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("reset values wrong");

	property p_rtc_preload;
		rtc_entry |=> joined == RTC_PRELOAD;
	endproperty
	a_rtc_preload: assert property (p_rtc_preload) else $error("calendar preload missing");

	property p_joined_read;
		state == BUS_IDLE && read && address == OFF_TAR && !is_split |=> readdata == $past(joined);
	endproperty
	a_joined_read: assert property (p_joined_read) else $error("joined count read wrong");

	property p_joined_load;
		acc_wr && address == OFF_TAILR && !is_split && byteenable == 4'hF |=> {ilr[1], ilr[0]} == $past(writedata);
	endproperty
	a_joined_load: assert property (p_joined_load) else $error("joined load write wrong");

	property p_reload32;
		to32 && !acc_wr |=> joined == $past({ilr[1], ilr[0]});
	endproperty
	a_reload32: assert property (p_reload32) else $error("joined reload wrong");

	property p_oneshot_stop;
		to32 && mode[0] == MODE_ONESHOT && !acc_wr |=> !ctl.tmr[0].en ##1 joined == $past(joined);
	endproperty
	a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot did not stop");

	property p_timeout_raw;
		to_a |=> ris[IRQ_A_TO];
	endproperty
	a_timeout_raw: assert property (p_timeout_raw) else $error("time-out status not set");

	property p_trigger;
		adc_trigger |-> $past((to_a && ctl.tmr[0].ote) || (to_b && ctl.tmr[1].ote));
	endproperty
	a_trigger: assert property (p_trigger) else $error("trigger without enable");

	property p_freeze;
		is_split && ctl.tmr[0].stall && !acc_wr |=> cnt[0] == $past(cnt[0]) && pre[0] == $past(pre[0]);
	endproperty
	a_freeze: assert property (p_freeze) else $error("frozen timer moved");

	property p_load_next;
		s_load_write |=> cnt[0] == $past(wm[15:0]);
	endproperty
	a_load_next: assert property (p_load_next) else $error("load write not taken");

	property p_prescale;
		run16[0] && pre[0] == 8'h00 && cnt[0] != 16'h0000 && !acc_wr |=> cnt[0] == $past(cnt[0]) - 16'h0001;
	endproperty
	a_prescale: assert property (p_prescale) else $error("prescaled step wrong");

	property p_rtc_wrap;
		rtc_hit && !acc_wr |=> joined == 32'h0000_0000 && ris[IRQ_RTC];
	endproperty
	a_rtc_wrap: assert property (p_rtc_wrap) else $error("calendar match wrong");

	property p_rtc_no_freeze;
		is_rtc && ctl.tmr[0].en && ctl.rtc_en && rtc_tick && joined != match && !acc_wr |=> joined == $past(joined) + 1;
	endproperty
	a_rtc_no_freeze: assert property (p_rtc_no_freeze) else $error("calendar frozen");

	property p_rtc_irq;
		rtc_hit && imr[IRQ_RTC] |-> ##2 irq;
	endproperty
	a_rtc_irq: assert property (p_rtc_irq) else $error("calendar interrupt missing");
endmodule

// file: rtl/gpt_pkg.sv
// Purpose: Shared constants and types for the general purpose timer pair
// Assumes: 32-bit Avalon-MM register access, byte addresses on word boundaries
// Notes:   Offsets are word aligned byte addresses
package gpt_pkg;
	localparam int ADDR_W = 8;

	// Register byte offsets
	localparam logic [7:0] OFF_CFG   = 8'h00;
	localparam logic [7:0] OFF_FIRST_MODE_FIELD  = 8'h04;
	localparam logic [7:0] OFF_TBMR  = 8'h08;
	localparam logic [7:0] OFF_CTL   = 8'h0C;
	localparam logic [7:0] OFF_IMR   = 8'h18;
	localparam logic [7:0] OFF_RIS   = 8'h1C;
	localparam logic [7:0] OFF_MIS   = 8'h20;
	localparam logic [7:0] OFF_ICR   = 8'h24;
	localparam logic [7:0] OFF_TAILR = 8'h28;
	localparam logic [7:0] OFF_TBILR = 8'h2C;
	localparam logic [7:0] OFF_MATCH = 8'h30;
	localparam logic [7:0] OFF_TAPR  = 8'h38;
	localparam logic [7:0] OFF_TBPR  = 8'h3C;
	localparam logic [7:0] OFF_TAR   = 8'h48;
	localparam logic [7:0] OFF_TBR   = 8'h4C;

	// Width configuration codes
	localparam logic [2:0] CFG_JOIN_TMR = 3'h0;
	localparam logic [2:0] CFG_JOIN_RTC = 3'h1;
	localparam logic [2:0] CFG_SPLIT    = 3'h4;

	// Per timer mode field codes
	localparam logic [1:0] MODE_ONESHOT  = 2'h1;
	localparam logic [1:0] MODE_PERIODIC = 2'h2;

	// Control register bit positions
	localparam int CTL_A_EN    = 0;
	localparam int CTL_A_STALL = 1;
	localparam int CTL_RTC_EN  = 4;
	localparam int CTL_A_OTE   = 5;
	localparam int CTL_B_EN    = 8;
	localparam int CTL_B_STALL = 9;
	localparam int CTL_B_OTE   = 13;

	// Interrupt status bit positions
	localparam int IRQ_A_TO = 0;
	localparam int IRQ_RTC  = 3;
	localparam int IRQ_B_TO = 8;
	localparam logic [31:0] IRQ_BITS = 32'h0000_0109;

	// Reset and preload values
	localparam logic [15:0] CNT_RST     = 16'hFFFF;
	localparam logic [15:0] ILR_RST     = 16'hFFFF;
	localparam logic [7:0]  PR_RST      = 8'h00;
	localparam logic [31:0] RTC_PRELOAD = 32'h0000_0001;

	// Calendar input rate and tick rate, in Hz
	localparam int RTC_IN_HZ   = 32768;
	localparam int RTC_OUT_HZ  = 1;
	localparam int RTC_DIV_DEF = RTC_IN_HZ / RTC_OUT_HZ;

	typedef struct packed {
		logic ote;
		logic stall;
		logic en;
	} timer_ctl_t;

	typedef struct packed {
		logic          rtc_en;
		timer_ctl_t [1:0] tmr;
	} ctl_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_ACK  = 2'b01
	} bus_state_t;
endpackage

// file: tb/tb_top.sv
// Purpose: Self-checking bench for the general purpose timer pair
// Assumes: One wait state bus slave; calendar divider shortened to 4
// Notes:   Only one timer drives the trigger at any time
module tb_top;
	import gpt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int DIV = 4;
	logic              core_clk, rst_n, read, write, capture_pin_zero, irq, adc_trigger, waitrequest, pin_run;
	logic [ADDR_W-1:0] address;
	logic [31:0]       writedata, readdata, rd, snap;
	logic [3:0]        byteenable;
	int                failures = 0;
	int                check_count = 0;
	int                trig_cnt = 0;
	int                cyc, t0, n;
	logic [7:0]        rst_addr [12];
	logic [31:0]       rst_val  [12];

	general_purpose_timer_pair #(.RTC_DIV(DIV)) i_general_purpose_timer_pair (
		.core_clk         (core_clk),
		.rst_n            (rst_n),
		.address          (address),
		.read             (read),
		.write            (write),
		.writedata        (writedata),
		.byteenable       (byteenable),
		.capture_pin_zero (capture_pin_zero),
		.readdata         (readdata),
		.waitrequest      (waitrequest),
		.irq              (irq),
		.adc_trigger      (adc_trigger)
	);

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// Half period of 1526 cycles gives about 32.77 kHz
	always begin
		repeat (1526) @(posedge core_clk);
		if (pin_run)
			capture_pin_zero <= ~capture_pin_zero;
	end

	// Sampled before the edge's own updates land
	always @(posedge core_clk)
		if (adc_trigger === 1'b1)
			trig_cnt <= trig_cnt + 1;

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Request held until waitrequest is sampled low at a rising edge; data taken at that edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= ~wr;
		do begin
			@(posedge core_clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 50);
		if (k >= 50)
			failures++;
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000, rd);
		chk(name, rd, exp);
	endtask

	// Cycles from call to the next trigger pulse
	task automatic wait_trig(output int c);
		c = 0;
		@(negedge core_clk);
		c++;
		while (adc_trigger !== 1'b1 && c < 200) begin
			@(negedge core_clk);
			c++;
		end
		if (c >= 200)
			failures++;
	endtask

	initial begin
		repeat (60000) @(posedge core_clk);
		failures++;
		end_of_test();
	end

	initial begin
		rst_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = '0;
		writedata = '0;
		byteenable = 4'hF;
		capture_pin_zero = 1'b0;
		pin_run = 1'b0;
		rst_addr = '{OFF_CFG, OFF_FIRST_MODE_FIELD, OFF_TBMR, OFF_CTL, OFF_IMR, OFF_RIS, OFF_TBILR, OFF_TAPR, OFF_TBPR,
			OFF_TAR, OFF_TBR, 8'hF0};
		rst_val = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_FFFF, 32'h0, 32'h0, 32'hFFFF_FFFF,
			32'h0000_FFFF, 32'h0};
		repeat (4) @(posedge core_clk);
		rst_n <= 1'b1;
		chk("irq at reset", {31'h0, irq}, 32'h0);
		chk("trigger at reset", {31'h0, adc_trigger}, 32'h0);
		for (int i = 0; i < 12; i++)
			rd_chk("reset value", rst_addr[i], rst_val[i]);

		// Joined one-shot, second mode field set to periodic
		wr(OFF_FIRST_MODE_FIELD, 32'(MODE_ONESHOT));
		wr(OFF_TBMR, 32'(MODE_PERIODIC));
		wr(OFF_TAILR, 32'h0001_0003);
		rd_chk("upper load", OFF_TBILR, 32'h0000_0001);
		rd_chk("joined count", OFF_TAR, 32'h0001_0003);
		wr(OFF_TAILR, 32'h0000_0005);
		wr(OFF_IMR, 32'h0000_0001);
		t0 = trig_cnt;
		wr(OFF_CTL, 32'h0000_0021);
		wait_trig(cyc);
		repeat (20) @(posedge core_clk);
		chk("one-shot pulses", 32'(trig_cnt - t0), 32'h1);
		rd_chk("enable cleared", OFF_CTL, 32'h0000_0020);
		rd_chk("reloaded count", OFF_TAR, 32'h0000_0005);
		rd_chk("raw time-out", OFF_RIS, 32'h0000_0001);
		rd_chk("masked time-out", OFF_MIS, 32'h0000_0001);
		chk("irq time-out", {31'h0, irq}, 32'h1);
		wr(OFF_ICR, 32'h0000_0001);
		rd_chk("raw cleared", OFF_RIS, 32'h0000_0000);
		repeat (2) @(posedge core_clk);
		chk("irq cleared", {31'h0, irq}, 32'h0);

		// Joined periodic, reload while running, freeze
		wr(OFF_FIRST_MODE_FIELD, 32'(MODE_PERIODIC));
		wr(OFF_CTL, 32'h0000_0021);
		wait_trig(cyc);
		wait_trig(cyc);
		chk("joined period", 32'(cyc), 32'd6);
		wr(OFF_TAILR, 32'h0000_0009);
		wait_trig(cyc);
		wait_trig(cyc);
		chk("new load period", 32'(cyc), 32'd10);
		wr(OFF_CTL, 32'h0000_0023);
		t0 = trig_cnt;
		xfer(1'b0, OFF_TAR, 32'h0, snap);
		repeat (25) @(posedge core_clk);
		rd_chk("frozen count", OFF_TAR, snap);
		chk("no pulse frozen", 32'(trig_cnt - t0), 32'h0);
		wr(OFF_CTL, 32'h0000_0021);
		t0 = failures;
		wait_trig(cyc);
		chk("resume after freeze", 32'(failures - t0), 32'h0);
		wr(OFF_CTL, 32'h0000_0000);
		wr(OFF_ICR, IRQ_BITS);

		// Split timers, first without trigger, second prescaled
		wr(OFF_CFG, 32'(CFG_SPLIT));
		wr(OFF_FIRST_MODE_FIELD, 32'(MODE_ONESHOT));
		wr(OFF_TBMR, 32'(MODE_PERIODIC));
		wr(OFF_TAILR, 32'h0000_0002);
		wr(OFF_TBILR, 32'h0000_0003);
		wr(OFF_TBPR, 32'h0000_0002);
		t0 = trig_cnt;
		wr(OFF_CTL, 32'h0000_0001);
		repeat (30) @(posedge core_clk);
		chk("gated trigger", 32'(trig_cnt - t0), 32'h0);
		rd_chk("first raw", OFF_RIS, 32'h0000_0001);
		rd_chk("first stopped", OFF_CTL, 32'h0000_0000);
		rd_chk("first 16-bit count", OFF_TAR, 32'h0000_0002);
		wr(OFF_CTL, 32'h0000_2100);
		wait_trig(cyc);
		wait_trig(cyc);
		chk("prescaled period", 32'(cyc), 32'd12);
		rd_chk("both raw", OFF_RIS, 32'h0000_0101);
		// A running one-shot would time out and drop its enable within a few cycles
		wr(OFF_CTL, 32'h0000_0003);
		repeat (30) @(posedge core_clk);
		rd_chk("split freeze keeps enable", OFF_CTL, 32'h0000_0003);
		rd_chk("split frozen count", OFF_TAR, 32'h0000_0002);
		wr(OFF_CTL, 32'h0000_0000);
		wr(OFF_ICR, IRQ_BITS);

		// Calendar with both freeze bits set
		wr(OFF_CFG, 32'(CFG_JOIN_RTC));
		rd_chk("calendar preload", OFF_TAR, RTC_PRELOAD);
		wr(OFF_MATCH, 32'h0000_0003);
		wr(OFF_IMR, 32'h0000_0008);
		pin_run <= 1'b1;
		wr(OFF_CTL, 32'h0000_0213);
		n = 0;
		while (irq !== 1'b1 && n < 50000) begin
			@(negedge core_clk);
			n++;
		end
		chk("calendar irq", {31'h0, irq}, 32'h1);
		rd_chk("calendar wrap", OFF_TAR, 32'h0000_0000);
		rd_chk("match raw", OFF_RIS, 32'h0000_0008);
		rd_chk("match masked", OFF_MIS, 32'h0000_0008);
		wr(OFF_ICR, 32'h0000_0008);
		rd_chk("match raw cleared", OFF_RIS, 32'h0000_0000);
		rd_chk("match masked cleared", OFF_MIS, 32'h0000_0000);
		pin_run <= 1'b0;
		end_of_test();
	end
endmodule
